// ---- hw/gsc_consts.vh ----
/*
 * Constants for the set/clear GPIO port: register addresses on the
 * serial register port, register width and reset values.
 * Assumes it is included by bare name from the design files under hw/.
 */
`ifndef GSC_CONSTS_VH
`define GSC_CONSTS_VH

// Register port geometry
`define GSC_ADDR_W 8
`define GSC_REG_W 8

// Direction register
`define GSC_ADDR_DIR_SET 8'h14
`define GSC_ADDR_DIR_CLR 8'h15

// Output value register
`define GSC_ADDR_OUT_SET 8'h16
`define GSC_ADDR_OUT_CLR 8'h17

// Pin input level, read only
`define GSC_ADDR_IN_LEVEL 8'h18

// Unused hole between input level and event latch
`define GSC_ADDR_GAP 8'h19

// Event latch
`define GSC_ADDR_LATCH_SET 8'h1a
`define GSC_ADDR_LATCH_CLR 8'h1b

// Falling-edge enable
`define GSC_ADDR_FALL_SET 8'h1c
`define GSC_ADDR_FALL_CLR 8'h1d

// Rising-edge enable
`define GSC_ADDR_RISE_SET 8'h1e
`define GSC_ADDR_RISE_CLR 8'h1f

// Reset values and the answer for unmapped reads
`define GSC_RESET_VALUE 8'h00
`define GSC_UNMAPPED_VALUE 8'h00
`define GSC_NO_EVENT 8'h00

// Clocks after reset release before edge events count
`define GSC_SETTLE_START 2'h0
`define GSC_SETTLE_COUNT 2'h3

`endif

// ---- hw/gsc_sync.v ----
/*
 * Two-flop level synchroniser, one lane per bit.
 * Assumes the inputs are asynchronous pins and clk_sys_in is the only clock.
 */
`timescale 1ns/1ns

module gsc_sync #(
    parameter WIDTH = 3
) (
    // Clock and reset
    input wire clk_sys_in,
    input wire rst_n_in,
    // Asynchronous levels and their synchronised copy
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] stage1;

    // Stage one feeds only stage two, to keep metastability contained
    always @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            stage1 <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end

endmodule

// ---- hw/gsc_setclr_reg.v ----
/*
 * One register with separate set and clear write strobes plus a
 * hardware set input.
 * Assumes the set and clear strobes are decoded from distinct addresses,
 * so at most one of them is high in any cycle.
 */
`timescale 1ns/1ns
`include "gsc_consts.vh"

module gsc_setclr_reg #(
    parameter WIDTH = 8,
    parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
    // Clock and reset
    input wire clk_sys_in,
    input wire rst_n_in,
    // Software write strobes and byte
    input wire set_wr_in,
    input wire clr_wr_in,
    input wire [WIDTH-1:0] wdata_in,
    // Hardware set, one bit per position
    input wire [WIDTH-1:0] hw_set_in,
    // Stored value
    output reg [WIDTH-1:0] value_out
);

    wire [WIDTH-1:0] set_mask;
    wire [WIDTH-1:0] clr_mask;
    wire [WIDTH-1:0] next_value;

    assign set_mask = set_wr_in ? wdata_in : {WIDTH{1'b0}};
    assign clr_mask = clr_wr_in ? wdata_in : {WIDTH{1'b0}};

    // Hardware set applied after the clear, so a same-cycle event survives
    assign next_value = (value_out & ~clr_mask) | set_mask | hw_set_in;

    always @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            value_out <= RESET_VALUE;
        end else begin
            value_out <= next_value;
        end
    end

endmodule

// ---- hw/gsc_port.v ----
/*
 * Three-pin general-purpose I/O port with set/clear register pairs,
 * an input level register, per-pin edge event latch and an event request.
 * Assumes a serial register interface elsewhere in the device turns bus
 * transactions into single-cycle read and write strobes on this port,
 * all on clk_sys_in, and that an outside pad ring resolves the pins
 * from gpio_level_out and gpio_drive_en_out.
 * Limitations: pin pulses shorter than about one clock can be missed,
 * and a pin driven as an output still raises events from its own level.
 * Edge events are held off for three clocks after reset release, so a
 * pin idling high gives no false edge; edges in that time are lost.
 */
// Behaviour
// - Writing the set address sets every bit written as one.
// - Writing the clear address clears every bit written as one.
// - Both addresses of a pair read the stored value, no side effect.
// - Output value register at 16h/17h drives pins configured as outputs.
// - Input register at 18h returns synchronised pin levels, pin 0 bit 0.
// - Event latch at 1Ah/1Bh marks pins with events; write one clears.
// - Falling-edge enable at 1Ch/1Dh permits events on one-to-zero.
// - Rising-edge enable at 1Eh/1Fh permits events on zero-to-one.
// - Bits 0 to 2 map to pins 0 to 2; bits 3 to 7 unassigned.
// - Direction register at 14h/15h: one means output, zero input.
`timescale 1ns/1ns
`include "gsc_consts.vh"

module gsc_port #(
    parameter NUM_PINS = 3
) (
    // Clock and reset
    input wire clk_sys_in,
    input wire rst_n_in,

    // Register port from the serial interface
    input wire [`GSC_ADDR_W-1:0] reg_addr_in,
    input wire reg_wr_in,
    input wire [`GSC_REG_W-1:0] reg_wdata_in,
    input wire reg_rd_in,
    output reg [`GSC_REG_W-1:0] reg_rdata_out,
    output reg reg_rvalid_out,
    output reg reg_unmapped_out,

    // General-purpose pins, split into three signals each
    input wire [NUM_PINS-1:0] gpio_pin_in,
    output wire [NUM_PINS-1:0] gpio_level_out,
    output wire [NUM_PINS-1:0] gpio_drive_en_out,

    // Event request toward the device interrupt output
    output reg gpio_event_req_out
);

    // Write strobes per register address
    wire dir_set_wr;
    wire dir_clr_wr;
    wire out_set_wr;
    wire out_clr_wr;
    wire latch_set_wr;
    wire latch_clr_wr;
    wire fall_set_wr;
    wire fall_clr_wr;
    wire rise_set_wr;
    wire rise_clr_wr;

    // Stored register values
    wire [`GSC_REG_W-1:0] dir_value;
    wire [`GSC_REG_W-1:0] out_value;
    wire [`GSC_REG_W-1:0] latch_value;
    wire [`GSC_REG_W-1:0] fall_enable;
    wire [`GSC_REG_W-1:0] rise_enable;

    // Pin sampling and edge detection
    wire [NUM_PINS-1:0] pin_sync;
    reg [NUM_PINS-1:0] pin_prev;
    reg [1:0] settle_cnt;
    wire [1:0] next_settle;
    wire edges_armed;
    wire [`GSC_REG_W-1:0] in_level;
    wire [`GSC_REG_W-1:0] pin_events;

    // Read path
    reg [`GSC_REG_W-1:0] next_rdata;
    wire next_unmapped;
    wire addr_mapped;

    // Write decode: each set/clear address is its own strobe
    assign dir_set_wr = reg_wr_in &&
        (reg_addr_in == `GSC_ADDR_DIR_SET);
    assign dir_clr_wr = reg_wr_in &&
        (reg_addr_in == `GSC_ADDR_DIR_CLR);
    assign out_set_wr = reg_wr_in &&
        (reg_addr_in == `GSC_ADDR_OUT_SET);
    assign out_clr_wr = reg_wr_in &&
        (reg_addr_in == `GSC_ADDR_OUT_CLR);
    assign latch_set_wr = reg_wr_in &&
        (reg_addr_in == `GSC_ADDR_LATCH_SET);
    assign latch_clr_wr = reg_wr_in &&
        (reg_addr_in == `GSC_ADDR_LATCH_CLR);
    assign fall_set_wr = reg_wr_in &&
        (reg_addr_in == `GSC_ADDR_FALL_SET);
    assign fall_clr_wr = reg_wr_in &&
        (reg_addr_in == `GSC_ADDR_FALL_CLR);
    assign rise_set_wr = reg_wr_in &&
        (reg_addr_in == `GSC_ADDR_RISE_SET);
    assign rise_clr_wr = reg_wr_in &&
        (reg_addr_in == `GSC_ADDR_RISE_CLR);

    // Direction register
    gsc_setclr_reg #(
        .WIDTH(`GSC_REG_W),
        .RESET_VALUE(`GSC_RESET_VALUE)
    ) u_dir_reg (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .set_wr_in(dir_set_wr),
        .clr_wr_in(dir_clr_wr),
        .wdata_in(reg_wdata_in),
        .hw_set_in(`GSC_NO_EVENT),
        .value_out(dir_value)
    );

    // Output value register
    gsc_setclr_reg #(
        .WIDTH(`GSC_REG_W),
        .RESET_VALUE(`GSC_RESET_VALUE)
    ) u_out_reg (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .set_wr_in(out_set_wr),
        .clr_wr_in(out_clr_wr),
        .wdata_in(reg_wdata_in),
        .hw_set_in(`GSC_NO_EVENT),
        .value_out(out_value)
    );

    // Event latch; pin events set bits and win over a same-cycle clear
    gsc_setclr_reg #(
        .WIDTH(`GSC_REG_W),
        .RESET_VALUE(`GSC_RESET_VALUE)
    ) u_latch_reg (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .set_wr_in(latch_set_wr),
        .clr_wr_in(latch_clr_wr),
        .wdata_in(reg_wdata_in),
        .hw_set_in(pin_events),
        .value_out(latch_value)
    );

    // Falling-edge enable mask
    gsc_setclr_reg #(
        .WIDTH(`GSC_REG_W),
        .RESET_VALUE(`GSC_RESET_VALUE)
    ) u_fall_reg (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .set_wr_in(fall_set_wr),
        .clr_wr_in(fall_clr_wr),
        .wdata_in(reg_wdata_in),
        .hw_set_in(`GSC_NO_EVENT),
        .value_out(fall_enable)
    );

    // Rising-edge enable mask
    gsc_setclr_reg #(
        .WIDTH(`GSC_REG_W),
        .RESET_VALUE(`GSC_RESET_VALUE)
    ) u_rise_reg (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .set_wr_in(rise_set_wr),
        .clr_wr_in(rise_clr_wr),
        .wdata_in(reg_wdata_in),
        .hw_set_in(`GSC_NO_EVENT),
        .value_out(rise_enable)
    );

    // Pins are asynchronous to clk_sys_in
    gsc_sync #(
        .WIDTH(NUM_PINS)
    ) u_pin_sync (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .async_in(gpio_pin_in),
        .sync_out(pin_sync)
    );

    // Previous synchronised level for edge comparison
    always @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            pin_prev <= {NUM_PINS{1'b0}};
        end else begin
            pin_prev <= pin_sync;
        end
    end

    // Held off until sync and prev both carry real pin levels; prev
    // starts at zero, so a pin idling high would look like a rise
    assign edges_armed = (settle_cnt == `GSC_SETTLE_COUNT);
    assign next_settle = edges_armed ? settle_cnt : settle_cnt + 2'h1;
    always @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            settle_cnt <= `GSC_SETTLE_START;
        end else begin
            settle_cnt <= next_settle;
        end
    end

    // Per-bit mapping: pins on the low bits, the rest carry no pin
    genvar i;
    generate
        for (i = 0; i < `GSC_REG_W; i = i + 1) begin : g_bit
            if (i < NUM_PINS) begin : g_pin
                wire rise_seen;
                wire fall_seen;
                // Level read back, pin i in bit i
                assign in_level[i] = pin_sync[i];
                // Edges against last cycle's synchronised level
                assign rise_seen = pin_sync[i] & ~pin_prev[i];
                assign fall_seen = ~pin_sync[i] & pin_prev[i];
                // One-cycle event per qualifying edge, once armed
                assign pin_events[i] = edges_armed &
                    ((rise_enable[i] & rise_seen) |
                    (fall_enable[i] & fall_seen));
                // Drive only while configured as an output
                assign gpio_level_out[i] = out_value[i];
                assign gpio_drive_en_out[i] = dir_value[i];
            end else begin : g_nopin
                // Unassigned bits see no pin and raise no event
                assign in_level[i] = 1'b0;
                assign pin_events[i] = 1'b0;
            end
        end
    endgenerate

    // Address map for reads
    assign addr_mapped =
        (reg_addr_in >= `GSC_ADDR_DIR_SET) &&
        (reg_addr_in <= `GSC_ADDR_RISE_CLR) &&
        (reg_addr_in != `GSC_ADDR_GAP);

    // Flag covers the hole at 19h and anything outside the map
    assign next_unmapped = (reg_rd_in | reg_wr_in) & ~addr_mapped;

    // Read mux: either address of a pair returns the same value
    always @* begin
        next_rdata = `GSC_UNMAPPED_VALUE;
        case (reg_addr_in)
            `GSC_ADDR_DIR_SET,
            `GSC_ADDR_DIR_CLR: begin
                next_rdata = dir_value;
            end
            `GSC_ADDR_OUT_SET,
            `GSC_ADDR_OUT_CLR: begin
                next_rdata = out_value;
            end
            `GSC_ADDR_IN_LEVEL: begin
                next_rdata = in_level;
            end
            `GSC_ADDR_LATCH_SET,
            `GSC_ADDR_LATCH_CLR: begin
                next_rdata = latch_value;
            end
            `GSC_ADDR_FALL_SET,
            `GSC_ADDR_FALL_CLR: begin
                next_rdata = fall_enable;
            end
            `GSC_ADDR_RISE_SET,
            `GSC_ADDR_RISE_CLR: begin
                next_rdata = rise_enable;
            end
            default: begin
                next_rdata = `GSC_UNMAPPED_VALUE;
            end
        endcase
    end

    // Read data registered; reads touch no stored bit
    always @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= `GSC_RESET_VALUE;
            reg_rvalid_out <= 1'b0;
            reg_unmapped_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_rd_in;
            reg_unmapped_out <= next_unmapped;
            if (reg_rd_in) begin
                reg_rdata_out <= next_rdata;
            end
        end
    end

    // Request follows the latch; includes software-set spare bits
    always @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            gpio_event_req_out <= 1'b0;
        end else begin
            gpio_event_req_out <= |latch_value;
        end
    end

endmodule

// ---- verification/gsc_port_chk.sv ----
/* Checker for gsc_port: register answers, pin drive and input path.
   Assumes reads and writes never share a cycle; bound below. */
`timescale 1ns/1ns
module gsc_port_chk #(
    parameter NUM_PINS = 3
) (
    // Clock and reset
    input wire clk_sys_in,
    input wire rst_n_in,
    // Register port
    input wire [7:0] reg_addr_in,
    input wire reg_wr_in,
    input wire [7:0] reg_wdata_in,
    input wire reg_rd_in,
    input wire [7:0] reg_rdata_out,
    input wire reg_rvalid_out,
    input wire reg_unmapped_out,
    // Pins and request
    input wire [NUM_PINS-1:0] gpio_pin_in,
    input wire [NUM_PINS-1:0] gpio_level_out,
    input wire [NUM_PINS-1:0] gpio_drive_en_out,
    input wire gpio_event_req_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);

    chk_rd_answer: assert property (
        reg_rd_in |=> reg_rvalid_out)
        else $error("read not answered");
    chk_rvalid_cause: assert property (
        reg_rvalid_out |-> $past(reg_rd_in))
        else $error("answer without read");
    chk_rd_quiet: assert property (
        reg_rd_in |=> $stable(gpio_level_out) && $stable(gpio_drive_en_out))
        else $error("read changed outputs");
    chk_out_set: assert property (
        reg_wr_in && reg_addr_in == 8'h16 |=> gpio_level_out ==
        ($past(gpio_level_out) | $past(reg_wdata_in[2:0])))
        else $error("output set wrong");
    chk_out_clr: assert property (
        reg_wr_in && reg_addr_in == 8'h17 |=> gpio_level_out ==
        ($past(gpio_level_out) & ~$past(reg_wdata_in[2:0])))
        else $error("output clear wrong");
    chk_dir_set: assert property (
        reg_wr_in && reg_addr_in == 8'h14 |=> gpio_drive_en_out ==
        ($past(gpio_drive_en_out) | $past(reg_wdata_in[2:0])))
        else $error("direction set wrong");
    chk_dir_clr: assert property (
        reg_wr_in && reg_addr_in == 8'h15 |=> gpio_drive_en_out ==
        ($past(gpio_drive_en_out) & ~$past(reg_wdata_in[2:0])))
        else $error("direction clear wrong");
    chk_level_hold: assert property (
        !reg_wr_in |=> $stable(gpio_level_out))
        else $error("level moved without write");
    // Pin held three samples so the synchroniser has settled
    chk_in_level: assert property (
        reg_rd_in && reg_addr_in == 8'h18 && $stable(gpio_pin_in) &&
        $past(gpio_pin_in, 2) == gpio_pin_in |=>
        reg_rdata_out == {5'h00, $past(gpio_pin_in)})
        else $error("input level wrong");
    chk_unmapped_flag: assert property (
        reg_rd_in || reg_wr_in |=> reg_unmapped_out ==
        ($past(reg_addr_in) < 8'h14 || $past(reg_addr_in) > 8'h1f ||
        $past(reg_addr_in) == 8'h19))
        else $error("unmapped flag wrong");
    chk_req_fall: assert property (
        $fell(gpio_event_req_out) |->
        $past(reg_wr_in && reg_addr_in == 8'h1b, 2))
        else $error("request dropped without clear");
endmodule

bind gsc_port gsc_port_chk #(.NUM_PINS(NUM_PINS)) gsc_port_chk_inst (
    .clk_sys_in, .rst_n_in, .reg_addr_in, .reg_wr_in, .reg_wdata_in,
    .reg_rd_in, .reg_rdata_out, .reg_rvalid_out, .reg_unmapped_out,
    .gpio_pin_in, .gpio_level_out, .gpio_drive_en_out, .gpio_event_req_out);

// ---- verification/gsc_pad_model.sv ----
/* Pad ring model for the three GPIO pins.
   Assumes a board driver pushes every pin the port leaves released. */
`timescale 1ns/1ns
module gsc_pad_model (
    // Port side
    input wire [2:0] level_in,
    input wire [2:0] drive_en_in,
    // Board side
    input wire [2:0] ext_in,
    output wire [2:0] pin_out
);
    // Port drive wins over the weaker board driver
    assign pin_out = (drive_en_in & level_in) |
        (~drive_en_in & ext_in);
endmodule

// ---- verification/gsc_port_tb.sv ----
/* Self-checking bench for gsc_port with register tasks and pad model.
   Assumes one 100 MHz clock and the default three pins. */
`timescale 1ns/1ns
module gsc_port_tb;
    logic clk_sys_in = 1'h0;
    logic rst_n_in = 1'h0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, u;
    logic wr = 1'h0, rd = 1'h0, rvalid, unmapped, req;
    logic [2:0] ext = 3'h0, pin, level, drv;
    logic [7:0] regs [5] = '{8'h14, 8'h16, 8'h1a, 8'h1c, 8'h1e};
    int err_total = 0, cmp_count = 0, cyc = 0;

    gsc_port gsc_port_inst (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
        .reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wdata),
        .reg_rd_in(rd), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
        .reg_unmapped_out(unmapped), .gpio_pin_in(pin),
        .gpio_level_out(level), .gpio_drive_en_out(drv),
        .gpio_event_req_out(req));
    gsc_pad_model gsc_pad_model_inst (.level_in(level),
        .drive_en_in(drv), .ext_in(ext), .pin_out(pin));

    initial begin
        forever #5 clk_sys_in = ~clk_sys_in;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk_sys_in);
        wr <= 1'h0;
    endtask

    // Answer is one cycle late; look at it mid-cycle
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys_in);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk_sys_in);
        rd <= 1'h0;
        @(negedge clk_sys_in);
        chk({7'h00, rvalid}, 8'h01);
        u = {7'h00, unmapped};
        chk(rdata, e);
    endtask

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    always @(posedge clk_sys_in) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            final_report();
        end
    end

    initial begin
        repeat (12) @(posedge clk_sys_in);
        rst_n_in <= 1'h1;
        for (int i = 8'h14; i <= 8'h1f; i++)
            rd_chk(i[7:0], 8'h00);
        foreach (regs[k]) begin
            wr_reg(regs[k], 8'h28);
            wr_reg(regs[k], 8'h88);
            rd_chk(regs[k], 8'ha8);
            rd_chk(regs[k] + 8'h01, 8'ha8);
            wr_reg(regs[k] + 8'h01, 8'h88);
            rd_chk(regs[k], 8'h20);
            wr_reg(regs[k] + 8'h01, 8'hff);
            rd_chk(regs[k] + 8'h01, 8'h00);
        end
        wr_reg(8'h14, 8'h05);
        wr_reg(8'h16, 8'h03);
        @(negedge clk_sys_in);
        chk({5'h00, drv}, 8'h05);
        chk({5'h00, level}, 8'h03);
        // Pin change needs two edges through the synchroniser
        @(posedge clk_sys_in);
        ext <= 3'h2;
        repeat (2) @(posedge clk_sys_in);
        rd_chk(8'h18, 8'h03);
        // Read-only place flags nothing, the hole at 19h does
        wr_reg(8'h18, 8'hff);
        @(negedge clk_sys_in);
        chk({7'h00, unmapped}, 8'h00);
        wr_reg(8'h19, 8'hff);
        @(negedge clk_sys_in);
        chk({7'h00, unmapped}, 8'h01);
        rd_chk(8'h18, 8'h03);
        rd_chk(8'h19, 8'h00);
        chk(u, 8'h01);
        // Released pin 0 falls while both masks are off
        wr_reg(8'h15, 8'hff);
        repeat (2) @(posedge clk_sys_in);
        rd_chk(8'h18, 8'h02);
        rd_chk(8'h1a, 8'h00);
        wr_reg(8'h1e, 8'h01);
        wr_reg(8'h1c, 8'h02);
        @(posedge clk_sys_in);
        ext <= 3'h1;
        repeat (3) @(posedge clk_sys_in);
        ext <= 3'h4;
        rd_chk(8'h1a, 8'h03);
        chk({7'h00, req}, 8'h01);
        wr_reg(8'h1b, 8'h01);
        rd_chk(8'h1a, 8'h02);
        chk({7'h00, req}, 8'h01);
        wr_reg(8'h1b, 8'h02);
        rd_chk(8'h1a, 8'h00);
        chk({7'h00, req}, 8'h00);
        @(posedge clk_sys_in);
        ext <= 3'h5;
        repeat (3) @(posedge clk_sys_in);
        rd_chk(8'h1a, 8'h01);
        // Mid-run reset while pins 0 and 2 stand high
        @(posedge clk_sys_in);
        rst_n_in <= 1'h0;
        repeat (3) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        chk({2'h0, level, drv}, 8'h00);
        chk(rdata, 8'h00);
        chk({7'h00, req}, 8'h00);
        @(posedge clk_sys_in);
        rst_n_in <= 1'h1;
        // Rise mask armed at once must see no false edge
        wr_reg(8'h1e, 8'h05);
        repeat (4) @(posedge clk_sys_in);
        rd_chk(8'h1a, 8'h00);
        rd_chk(8'h18, 8'h05);
        // A real rise after that is still caught
        @(posedge clk_sys_in);
        ext <= 3'h4;
        repeat (3) @(posedge clk_sys_in);
        ext <= 3'h5;
        repeat (3) @(posedge clk_sys_in);
        rd_chk(8'h1a, 8'h01);
        final_report();
    end
endmodule
